// >>> bcs_pkg.sv
// constants, field layout and types of the blit control/status front end
// assumes a 32-bit avalon-mm slave with byte addresses and a 16-entry fifo
//
// Function
// R1: format bit picks 8 or 16 bpp
// R2: destination linear select means no stride
// R3: destination rectangle advances by offset register
// R4: source linear select means no stride
// R5: source rectangle advances by offset register
// R6: enable write starts; reads return zero
// R7: host never clears enable while busy
// R8: busy reads one while operation runs
// R9: used count in bits 28 to 24
// R10: free count in bits 20 to 16
// R11: not-empty flag at bit 6
// R12: half-full flag at bit 5
// R13: full flag at bit 4
// R14: flags encode 0, 1-6, 7-14, 15-16
// R15: read pauses when full, resumes below 14
// R16: busy visible the cycle after start
`default_nettype none
package bcs_pkg;
   // register byte offsets
   localparam logic [15:0] BCS_OFS_CTL  = 16'h8000;
   localparam logic [15:0] BCS_OFS_STAT = 16'h8004;
   // control register field positions
   localparam int BCS_CTL_FMT_BIT  = 18;  // colour format select
   localparam int BCS_CTL_DLIN_BIT = 17;  // destination linear select
   localparam int BCS_CTL_SLIN_BIT = 16;  // source linear select
   localparam int BCS_CTL_EN_BIT   = 0;   // write-only enable
   // status register field positions
   localparam int BCS_ST_USED_LSB = 24;   // used entry count
   localparam int BCS_ST_FREE_LSB = 16;   // free entry count
   localparam int BCS_ST_NE_BIT   = 6;    // not-empty flag
   localparam int BCS_ST_HF_BIT   = 5;    // half-full flag
   localparam int BCS_ST_FULL_BIT = 4;    // full flag
   localparam int BCS_ST_BUSY_BIT = 0;    // busy flag
   // fifo geometry and flag thresholds
   localparam int BCS_FIFO_DEPTH = 16;
   localparam int BCS_CNT_W      = 5;
   localparam logic [4:0] BCS_NE_MIN     = 5'h01;
   localparam logic [4:0] BCS_HF_MIN     = 5'h07;
   localparam logic [4:0] BCS_FULL_MIN   = 5'h0F;
   localparam logic [4:0] BCS_RESUME_LT  = 5'h0E;
   // reset values
   localparam logic [31:0] BCS_DATA_RST  = 32'h0000_0000;
   localparam logic [4:0]  BCS_CNT_RST   = 5'h00;
   // operation state
   typedef enum logic {BCS_IDLE, BCS_RUN} bcs_state_t;
endpackage : bcs_pkg
`default_nettype wire

// >>> bcs_fifo_level.sv
// occupancy tracker for the blit data fifo, with the status flags
// assumes push and pop strobes come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module bcs_fifo_level
   import bcs_pkg::*;
#(
   parameter int DEPTH = BCS_FIFO_DEPTH
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,       // synchronised reset
   input  wire logic                 push,        // one entry written
   input  wire logic                 pop,         // one entry read out
   output logic [BCS_CNT_W-1:0]      used_cnt,    // committed entries
   output logic [BCS_CNT_W-1:0]      free_cnt,    // empty entries
   output logic                      not_empty,   // at least one word
   output logic                      half_full,   // upper half band
   output logic                      full         // top band
);
   localparam logic [BCS_CNT_W-1:0] DEPTH_C = BCS_CNT_W'(DEPTH);

   logic [BCS_CNT_W-1:0] used_ff;       // occupancy register
   logic [BCS_CNT_W-1:0] nxt_used;
   logic                 do_push;       // push that fits
   logic                 do_pop;        // pop that has data

   // next occupancy; overflow and underflow strobes are dropped
   always_comb begin
      do_push  = push && (used_ff != DEPTH_C);
      do_pop   = pop && (used_ff != BCS_CNT_RST);
      nxt_used = used_ff;
      if (do_push && !do_pop) begin
         nxt_used = used_ff + BCS_CNT_W'(1);
      end else if (do_pop && !do_push) begin
         nxt_used = used_ff - BCS_CNT_W'(1);
      end
   end

   // occupancy register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         used_ff <= BCS_CNT_RST;
      end else begin
         used_ff <= nxt_used;
      end
   end

   // counts only what has landed in storage, so in-flight data is missed
   assign used_cnt  = used_ff;                      // see R9
   assign free_cnt  = DEPTH_C - used_ff;            // see R10
   // flag bands chosen so the three bits encode the fill level
   assign not_empty = used_ff >= BCS_NE_MIN;        // see R11 see R14
   assign half_full = used_ff >= BCS_HF_MIN;        // see R12 see R14
   assign full      = used_ff >= BCS_FULL_MIN;      // see R13 see R14

   a_free_sum: assert property (@(posedge clk) disable iff (!rst_n) // see R10
      (used_cnt + free_cnt) == DEPTH_C)
      else $error("used plus free is not the fifo depth");
   a_free_zero: assert property (@(posedge clk) disable iff (!rst_n) // see R10
      (free_cnt == BCS_CNT_RST) |-> full)
      else $error("zero free entries without full flag");
   a_empty_flag: assert property (@(posedge clk) disable iff (!rst_n) // see R11
      not_empty == (used_cnt != BCS_CNT_RST))
      else $error("not-empty flag disagrees with count");
   a_flag_bands: assert property (@(posedge clk) disable iff (!rst_n) // see R14
      (used_cnt == 5'd6 |-> !half_full) and (used_cnt == 5'd7 |-> half_full && !full)
      and (used_cnt == 5'd14 |-> !full) and (used_cnt == 5'd15 |-> full))
      else $error("fifo flags outside their bands");
   a_flag_order: assert property (@(posedge clk) disable iff (!rst_n) // see R13
      (full |-> half_full) and (half_full |-> not_empty))
      else $error("fifo flags not nested");
   a_push_count: assert property (@(posedge clk) disable iff (!rst_n) // see R9
      (push && !pop && used_cnt < DEPTH_C) |=> used_cnt == $past(used_cnt) + 5'd1)
      else $error("push did not raise the used count");
endmodule : bcs_fifo_level
`default_nettype wire

// >>> bcs_regs.sv
// control and status register front end of the blit engine
// assumes an avalon-mm master on clk and engine/fifo strobes on clk
`timescale 1ns/10ps
`default_nettype none
module bcs_regs
   import bcs_pkg::*;
#(
   parameter int ADDR_W = 16,             // byte address width
   parameter int DEPTH  = BCS_FIFO_DEPTH  // fifo entries
) (
   input  wire logic              clk,
   input  wire logic              rst_n,            // async, active low
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic [31:0]            avs_readdata,
   output logic                   avs_waitrequest,
   // engine side
   output logic                   eng_start,        // one-cycle start pulse
   output logic                   eng_pix_16bpp,    // 1: 16 bpp, 0: 8 bpp
   output logic                   eng_src_linear,   // source is linear
   output logic                   eng_dst_linear,   // destination is linear
   output logic                   eng_src_stride,   // source uses line offset
   output logic                   eng_dst_stride,   // destination uses line offset
   output logic                   eng_hold,         // pause a read operation
   input  wire logic              eng_done,         // operation finished pulse
   input  wire logic              eng_read_op,      // running op is a read
   // fifo strobes
   input  wire logic              fifo_push,        // engine wrote a word
   input  wire logic              fifo_pop          // host took a word
);
   // reset synchroniser
   logic rst_meta_ff;          // first stage, read only by the second
   logic rst_sync_ff;          // released reset used everywhere

   // bus handshake
   logic        ack_ff;        // high in the answering cycle
   logic        nxt_ack;
   logic [31:0] rdata_ff;      // read data register
   logic [31:0] nxt_rdata;
   logic        req;           // any request present
   logic        hit_ctl;       // control register addressed
   logic        hit_stat;      // status register addressed
   logic        wr_fire;       // write takes effect this edge

   // control fields
   logic        fmt_ff;
   logic        nxt_fmt;
   logic        dlin_ff;
   logic        nxt_dlin;
   logic        slin_ff;
   logic        nxt_slin;
   logic        start_ff;      // start pulse register
   logic        nxt_start;

   // operation state
   bcs_state_t  state_ff;
   bcs_state_t  nxt_state;
   logic        hold_ff;
   logic        nxt_hold;

   // fifo status
   logic [BCS_CNT_W-1:0] used_cnt;
   logic [BCS_CNT_W-1:0] free_cnt;
   logic        f_ne;
   logic        f_hf;
   logic        f_full;
   logic [31:0] stat_word;     // assembled status register

   // reset release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   // fifo occupancy and flags
   bcs_fifo_level #(
      .DEPTH     (DEPTH)
   ) u_level (
      .clk       (clk),
      .rst_n     (rst_sync_ff),
      .push      (fifo_push),
      .pop       (fifo_pop),
      .used_cnt  (used_cnt),
      .free_cnt  (free_cnt),
      .not_empty (f_ne),
      .half_full (f_hf),
      .full      (f_full)
   );

   // address decode; unmapped addresses read zero and drop writes
   assign req      = avs_read || avs_write;
   assign hit_ctl  = avs_address == ADDR_W'(BCS_OFS_CTL);
   assign hit_stat = avs_address == ADDR_W'(BCS_OFS_STAT);
   assign wr_fire  = avs_write && ack_ff;

   // one wait cycle, answer on the second edge of every request
   assign avs_waitrequest = req && !ack_ff;
   assign avs_readdata    = rdata_ff;

   // status word: counts, fifo flags and busy
   always_comb begin
      stat_word = BCS_DATA_RST;
      stat_word[BCS_ST_USED_LSB +: BCS_CNT_W] = used_cnt;   // see R9
      stat_word[BCS_ST_FREE_LSB +: BCS_CNT_W] = free_cnt;   // see R10
      stat_word[BCS_ST_NE_BIT]   = f_ne;                    // see R11
      stat_word[BCS_ST_HF_BIT]   = f_hf;                    // see R12
      stat_word[BCS_ST_FULL_BIT] = f_full;                  // see R13
      stat_word[BCS_ST_BUSY_BIT] = state_ff == BCS_RUN;     // see R8
   end

   // bus answer: capture read data in the wait cycle
   always_comb begin
      nxt_ack   = req && !ack_ff;
      nxt_rdata = rdata_ff;
      if (avs_read && !ack_ff) begin
         nxt_rdata = BCS_DATA_RST;
         if (hit_ctl) begin
            // enable bit is write-only and reads zero
            nxt_rdata[BCS_CTL_FMT_BIT]  = fmt_ff;
            nxt_rdata[BCS_CTL_DLIN_BIT] = dlin_ff;
            nxt_rdata[BCS_CTL_SLIN_BIT] = slin_ff;   // see R6
         end else if (hit_stat) begin
            nxt_rdata = stat_word;
         end
      end
   end

   // bus handshake registers
   always_ff @(posedge clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         ack_ff   <= 1'b0;
         rdata_ff <= BCS_DATA_RST;
      end else begin
         ack_ff   <= nxt_ack;
         rdata_ff <= nxt_rdata;
      end
   end

   // control fields; selects live in byte lane 2, enable in lane 0
   always_comb begin
      nxt_fmt   = fmt_ff;
      nxt_dlin  = dlin_ff;
      nxt_slin  = slin_ff;
      nxt_start = 1'b0;
      if (wr_fire && hit_ctl) begin
         if (avs_byteenable[2]) begin
            nxt_fmt  = avs_writedata[BCS_CTL_FMT_BIT];    // see R1
            nxt_dlin = avs_writedata[BCS_CTL_DLIN_BIT];   // see R2 see R3
            nxt_slin = avs_writedata[BCS_CTL_SLIN_BIT];   // see R4 see R5
         end
         // writing zero to enable is ignored, so clearing it mid-run
         // by a careless host does nothing
         if (avs_byteenable[0] && avs_writedata[BCS_CTL_EN_BIT]) begin
            nxt_start = 1'b1;                             // see R6 see R7
         end
      end
   end

   // control registers
   always_ff @(posedge clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         fmt_ff   <= 1'b0;
         dlin_ff  <= 1'b0;
         slin_ff  <= 1'b0;
         start_ff <= 1'b0;
      end else begin
         fmt_ff   <= nxt_fmt;
         dlin_ff  <= nxt_dlin;
         slin_ff  <= nxt_slin;
         start_ff <= nxt_start;
      end
   end

   // operation state and read-pause control
   always_comb begin
      nxt_state = state_ff;
      nxt_hold  = hold_ff;
      unique case (state_ff)
         BCS_IDLE: begin
            // busy rises at the same edge that takes the enable write
            if (nxt_start) begin
               nxt_state = BCS_RUN;                       // see R16
            end
         end
         BCS_RUN: begin
            // a new start in the done cycle keeps the engine busy
            if (eng_done && !nxt_start) begin
               nxt_state = BCS_IDLE;                      // see R8
            end
         end
      endcase
      // pause a read when full, release once below the resume mark
      if (state_ff != BCS_RUN || !eng_read_op) begin
         nxt_hold = 1'b0;
      end else if (used_cnt == BCS_CNT_W'(DEPTH)) begin
         nxt_hold = 1'b1;                                 // see R15
      end else if (used_cnt < BCS_RESUME_LT) begin
         nxt_hold = 1'b0;                                 // see R15
      end
   end

   // operation state registers
   always_ff @(posedge clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         state_ff <= BCS_IDLE;
         hold_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         hold_ff  <= nxt_hold;
      end
   end

   // engine outputs
   assign eng_start      = start_ff;                      // see R6
   assign eng_pix_16bpp  = fmt_ff;                        // see R1
   assign eng_src_linear = slin_ff;                       // see R4
   assign eng_dst_linear = dlin_ff;                       // see R2
   assign eng_src_stride = !slin_ff;                      // see R5
   assign eng_dst_stride = !dlin_ff;                      // see R3
   assign eng_hold       = hold_ff;

   // checks on the register side
   a_busy_after_en: assert property (@(posedge clk) disable iff (!rst_sync_ff) // see R16
      (wr_fire && hit_ctl && avs_byteenable[0] && avs_writedata[BCS_CTL_EN_BIT])
      |=> (state_ff == BCS_RUN) && eng_start)
      else $error("enable write did not make the block busy");
   a_busy_read: assert property (@(posedge clk) disable iff (!rst_sync_ff) // see R8
      (avs_read && !avs_waitrequest && hit_stat)
      |-> avs_readdata[BCS_ST_BUSY_BIT] == $past(state_ff == BCS_RUN))
      else $error("busy bit read back wrong");
   a_busy_clear: assert property (@(posedge clk) disable iff (!rst_sync_ff) // see R8
      (state_ff == BCS_RUN && eng_done && !nxt_start) |=> state_ff == BCS_IDLE)
      else $error("busy stayed after completion");
   a_enable_wo: assert property (@(posedge clk) disable iff (!rst_sync_ff) // see R6
      (avs_read && !avs_waitrequest && hit_ctl) |-> !avs_readdata[BCS_CTL_EN_BIT])
      else $error("enable bit read back as one");
   a_fmt_write: assert property (@(posedge clk) disable iff (!rst_sync_ff) // see R1
      (wr_fire && hit_ctl && avs_byteenable[2])
      |=> eng_pix_16bpp == $past(avs_writedata[BCS_CTL_FMT_BIT]))
      else $error("colour format not taken from write");
   a_layout_out: assert property (@(posedge clk) disable iff (!rst_sync_ff) // see R3
      (wr_fire && hit_ctl && avs_byteenable[2])
      |=> (eng_dst_stride == !$past(avs_writedata[BCS_CTL_DLIN_BIT]))
          && (eng_src_stride == !$past(avs_writedata[BCS_CTL_SLIN_BIT])))
      else $error("stride select not taken from write");
   a_hold_set: assert property (@(posedge clk) disable iff (!rst_sync_ff) // see R15
      (state_ff == BCS_RUN && eng_read_op && used_cnt == 5'd16) |=> eng_hold)
      else $error("read not paused at full fifo");
   a_hold_keep: assert property (@(posedge clk) disable iff (!rst_sync_ff) // see R15
      (eng_hold && eng_read_op && state_ff == BCS_RUN && used_cnt >= 5'd14) |=> eng_hold)
      else $error("read resumed with 14 or more entries");
   a_wait_one: assert property (@(posedge clk) disable iff (!rst_sync_ff) // see R16
      ($rose(req) |-> avs_waitrequest ##1 !avs_waitrequest))
      else $error("bus answer not after one wait cycle");
endmodule : bcs_regs
`default_nettype wire

// >>> bcs_engine_model.sv
// behavioural engine and fifo feeder standing beside the blit register front end
// assumes the bench drives run length, mode and push/pop requests at the rising edge
`timescale 1ns/10ps
`default_nettype none
module bcs_engine_model (
   input  wire logic       clk,
   input  wire logic       rst_n,        // async, active low
   input  wire logic       eng_start,    // start pulse from the registers
   input  wire logic       eng_hold,     // pause of a read operation
   input  wire logic [7:0] run_len,      // cycles one operation lasts
   input  wire logic       read_mode,    // operations started are reads
   input  wire logic       push_req,     // bench wants a word written
   input  wire logic       pop_req,      // bench takes a word
   output logic            eng_done,     // end of operation pulse
   output logic            eng_read_op,  // running operation is a read
   output logic            fifo_push,    // word written into the fifo
   output logic            fifo_pop      // word taken from the fifo
);
   logic [7:0] cnt_ff;    // cycles left in the running operation
   logic [7:0] nxt_cnt;
   logic       done_ff;   // registered end pulse
   logic       nxt_done;
   // count a started operation down and flag its last cycle
   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_done = 1'b0;
      if (eng_start) begin
         nxt_cnt = run_len;
      end else if (cnt_ff != 8'h00) begin
         nxt_cnt  = cnt_ff - 8'h01;
         nxt_done = (cnt_ff == 8'h01);
      end
   end
   // state registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff  <= 8'h00;
         done_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         done_ff <= nxt_done;
      end
   end
   assign eng_done    = done_ff;
   assign eng_read_op = read_mode && (cnt_ff != 8'h00);
   // a paused read operation writes nothing into the fifo
   assign fifo_push   = push_req && !(eng_read_op && eng_hold);
   assign fifo_pop    = pop_req;
endmodule : bcs_engine_model
`default_nettype wire

// >>> tb_blit_control_status.sv
// self-checking bench of the blit control/status front end
// assumes bcs_pkg, bcs_regs and the engine model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_blit_control_status
   import bcs_pkg::*;
;
   logic        clk;              // 40 MHz system clock
   logic        rst_n;            // raw reset, active low
   logic [15:0] avs_address;      // bus byte address
   logic        avs_read;         // bus read request
   logic        avs_write;        // bus write request
   logic [31:0] avs_writedata;    // bus write data
   logic [3:0]  avs_byteenable;   // all lanes on
   logic [31:0] avs_readdata;     // bus read data
   logic        avs_waitrequest;  // bus stall
   logic        eng_start;        // start pulse
   logic        eng_pix_16bpp;    // colour format
   logic        eng_src_linear;   // source linear
   logic        eng_dst_linear;   // destination linear
   logic        eng_src_stride;   // source uses offset
   logic        eng_dst_stride;   // destination uses offset
   logic        eng_hold;         // read pause
   logic        eng_done;         // end pulse from the model
   logic        eng_read_op;      // read op from the model
   logic        fifo_push;        // fifo write strobe
   logic        fifo_pop;         // fifo read strobe
   logic [7:0]  run_len;          // model operation length
   logic        read_mode;        // model runs read operations
   logic        push_req;         // bench push request
   logic        pop_req;          // bench pop request
   int          num_errors;       // mismatches
   int          n_tests;          // comparisons
   bcs_regs dut_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .eng_start(eng_start),
      .eng_pix_16bpp(eng_pix_16bpp), .eng_src_linear(eng_src_linear), .eng_dst_linear(eng_dst_linear),
      .eng_src_stride(eng_src_stride), .eng_dst_stride(eng_dst_stride), .eng_hold(eng_hold),
      .eng_done(eng_done), .eng_read_op(eng_read_op), .fifo_push(fifo_push), .fifo_pop(fifo_pop));
   bcs_engine_model eng_u (.clk(clk), .rst_n(rst_n), .eng_start(eng_start), .eng_hold(eng_hold),
      .run_len(run_len), .read_mode(read_mode), .push_req(push_req), .pop_req(pop_req),
      .eng_done(eng_done), .eng_read_op(eng_read_op), .fifo_push(fifo_push), .fifo_pop(fifo_pop));
   // free running clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // verdict and end of run
   task print_verdict;
      if (num_errors == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict
   // compare one value
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   // one bus transfer, held until waitrequest is seen low at a falling edge
   task bus_xfer(input logic wr, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
      int   i;
      logic ws;
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      for (i = 0; i < 20; i++) begin
         @(negedge clk);
         ws = avs_waitrequest;
         q  = avs_readdata;
         @(posedge clk);
         if (ws === 1'b0) break;
      end
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (i == 20) begin
         num_errors++;
         print_verdict();
      end
   endtask : bus_xfer
   task wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus_xfer(1'b1, a, d, q);
   endtask : wr
   task rd(input logic [15:0] a, output logic [31:0] q);
      bus_xfer(1'b0, a, 32'h0000_0000, q);
   endtask : rd
   // status word expected for a fill level and busy state
   function automatic logic [31:0] exp_stat(input int n, input logic b);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[BCS_ST_USED_LSB +: 5] = n[4:0];
      v[BCS_ST_FREE_LSB +: 5] = 5'(16 - n);
      v[BCS_ST_NE_BIT]   = (n >= 1);
      v[BCS_ST_HF_BIT]   = (n >= 7);
      v[BCS_ST_FULL_BIT] = (n >= 15);
      v[BCS_ST_BUSY_BIT] = b;
      return v;
   endfunction : exp_stat
   // n push or pop strobes in a row
   task push_n(input int n);
      @(posedge clk);
      push_req <= 1'b1;
      repeat (n) @(posedge clk);
      push_req <= 1'b0;
   endtask : push_n
   task pop_n(input int n);
      @(posedge clk);
      pop_req <= 1'b1;
      repeat (n) @(posedge clk);
      pop_req <= 1'b0;
   endtask : pop_n
   // poll busy until clear before touching the control register again
   task wait_idle;
      int          i;
      logic [31:0] q;
      q = 32'h0000_0001;
      for (i = 0; i < 100 && q[0] !== 1'b0; i++) rd(BCS_OFS_STAT, q);
      if (q[0] !== 1'b0) begin
         num_errors++;
         print_verdict();
      end
   endtask : wait_idle
   // reset values, unmapped read, ignored status write
   task t_reset;
      logic [31:0] q;
      rd(BCS_OFS_CTL, q);
      chk("ctl reset", 32'h0000_0000, q);
      rd(BCS_OFS_STAT, q);
      chk("status reset", exp_stat(0, 1'b0), q);
      rd(16'h8008, q);
      chk("unmapped read", 32'h0000_0000, q);
      wr(BCS_OFS_STAT, 32'hFFFF_FFFF);
      rd(BCS_OFS_STAT, q);
      chk("status after write", exp_stat(0, 1'b0), q);
   endtask : t_reset
   // every layout and format select, enable left at zero
   task t_selects;
      int          k;
      logic [2:0]  s;
      logic [31:0] q;
      for (k = 0; k < 8; k++) begin
         s = k[2:0];
         wr(BCS_OFS_CTL, {13'h0000, s, 16'h0000});
         @(negedge clk);
         chk("format", {31'h0, s[2]}, {31'h0, eng_pix_16bpp});
         chk("dst linear", {31'h0, s[1]}, {31'h0, eng_dst_linear});
         chk("dst stride", {31'h0, !s[1]}, {31'h0, eng_dst_stride});
         chk("src linear", {31'h0, s[0]}, {31'h0, eng_src_linear});
         chk("src stride", {31'h0, !s[0]}, {31'h0, eng_src_stride});
         chk("start idle", 32'h0, {31'h0, eng_start});
         rd(BCS_OFS_CTL, q);
         chk("ctl readback", {13'h0000, s, 16'h0000}, q);
      end
   endtask : t_selects
   // start pulse for one cycle, busy read while running, busy cleared at the end
   task t_start;
      logic [31:0] q;
      run_len <= 8'd20;
      wr(BCS_OFS_CTL, 32'h0005_0001);
      @(negedge clk);
      chk("start pulse", 32'h1, {31'h0, eng_start});
      @(negedge clk);
      chk("start ends", 32'h0, {31'h0, eng_start});
      rd(BCS_OFS_STAT, q);
      chk("busy after start", exp_stat(0, 1'b1), q);
      rd(BCS_OFS_CTL, q);
      chk("enable not read", 32'h0005_0000, q);
      wait_idle();
      rd(BCS_OFS_STAT, q);
      chk("busy cleared", exp_stat(0, 1'b0), q);
   endtask : t_start
   // every fill level from empty to full, a push past full, then drained to empty
   task t_levels;
      int          n;
      logic [31:0] q;
      for (n = 0; n <= 16; n++) begin
         rd(BCS_OFS_STAT, q);
         chk("fill status", exp_stat(n, 1'b0), q);
         push_n(1);
      end
      rd(BCS_OFS_STAT, q);
      chk("push at full", exp_stat(16, 1'b0), q);
      pop_n(17);
      rd(BCS_OFS_STAT, q);
      chk("drained", exp_stat(0, 1'b0), q);
   endtask : t_levels
   // read operation pauses at full and resumes below 14
   task t_hold;
      int          i;
      logic [31:0] q;
      run_len   <= 8'd255;
      read_mode <= 1'b1;
      wr(BCS_OFS_CTL, 32'h0000_0001);
      push_n(16);
      for (i = 0; i < 4 && eng_hold !== 1'b1; i++) @(negedge clk);
      chk("hold at full", 32'h1, {31'h0, eng_hold});
      rd(BCS_OFS_STAT, q);
      chk("full while busy", exp_stat(16, 1'b1), q);
      pop_n(2);
      repeat (4) @(negedge clk);
      chk("hold at 14", 32'h1, {31'h0, eng_hold});
      pop_n(1);
      for (i = 0; i < 4 && eng_hold !== 1'b0; i++) @(negedge clk);
      chk("resume at 13", 32'h0, {31'h0, eng_hold});
      pop_n(13);
      wait_idle();
      read_mode <= 1'b0;
   endtask : t_hold
   // reset, then the scenarios in turn
   initial begin
      rst_n          = 1'b0;
      avs_address    = 16'h0000;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = 32'h0000_0000;
      avs_byteenable = 4'hF;
      run_len        = 8'd20;
      read_mode      = 1'b0;
      push_req       = 1'b0;
      pop_req        = 1'b0;
      num_errors     = 0;
      n_tests        = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset();
      t_selects();
      t_start();
      t_levels();
      t_hold();
      print_verdict();
   end
endmodule : tb_blit_control_status
`default_nettype wire
